/* hdl/bgms_map.svh */
`ifndef BGMS_MAP_SVH
`define BGMS_MAP_SVH

// system clock period
`define BGMS_CLK_NS 50
// extra delay after the high-side gate has fallen
`define BGMS_DEAD_NS 50
`define BGMS_DEAD_CYC ((`BGMS_DEAD_NS + `BGMS_CLK_NS - 1) / `BGMS_CLK_NS)
// external sync acceptance window and ceiling
`define BGMS_SYNC_TOL_PCT 20
`define BGMS_SYNC_MAX_KHZ 2500
`define BGMS_CLK_KHZ (1000000 / `BGMS_CLK_NS)
`define BGMS_SYNC_MIN_CYC (`BGMS_CLK_KHZ / `BGMS_SYNC_MAX_KHZ)
// in-tolerance sync periods needed before lock
`define BGMS_LOCK_EDGES 2'h2
// missed cycles before sleep
`define BGMS_MISS_LIMIT 5'h10
// register map (byte addresses)
`define BGMS_CTRL_ADDR 12'h000
`define BGMS_STAT_ADDR 12'h004
`define BGMS_CTRL_RESET 32'h00000001
`define BGMS_CTRL_RUN_BIT 0
// strap decode codes from the comparator ladder
`define BGMS_STRAP_P_SS0_1PH 3'h0
`define BGMS_STRAP_P_SS1_1PH 3'h1
`define BGMS_STRAP_P_SS0_2PH 3'h2
`define BGMS_STRAP_P_SS1_2PH 3'h3
`define BGMS_STRAP_SECONDARY 3'h4

`endif

/* hdl/bgms_pkg.sv */
package bgms_pkg;
	// gate interlock states, one-hot
	typedef enum logic [5:0] {
		BGMS_IDLE = 6'h01,
		BGMS_LO_WAIT = 6'h02,
		BGMS_HS_ON = 6'h04,
		BGMS_HO_WAIT = 6'h08,
		BGMS_DEAD = 6'h10,
		BGMS_LS_ON = 6'h20
	} bgms_gate_e;
	// width of the bundle of asynchronous inputs
	typedef logic [13:0] bgms_async_t;
endpackage

/* hdl/bgms_sequencer.sv */
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "bgms_map.svh"
// Summary of operation
// - never drive both gates together
// - low side waits for high gate low
// - high side waits for low gate low
// - latch strap when bias rises, hold
// - strap decodes five configurations
// - spread-spectrum primary ignores external sync
// - strap pin then enables EMI filter
// - secondary disables error amplifier output
// - dual phase forbids internal compensation
// - dual primary drives antiphase sync out
// - secondary times from primary sync
// - lock external sync after three edges, two good periods
// - pulse skipping stops sync clock output
// - re-enabled secondary restarts soft-start
// - sixteen missed cycles in emulation sleep
// - zero cross turns low side off, only in diode emulation
// - mode pin high emulates diode, low forces
// - soft-start forces diode emulation
// - accept sync within tolerance, below ceiling
// - valid sync replaces oscillator, min-off ignores
// - overtemperature shuts down, restarts with hysteresis
module bgms_sequencer #(
	parameter int PERIOD_CYC = 40,
	parameter int SS_CYC = 400
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic bias_above_uvlo,
	input wire logic [2:0] strap_code,
	input wire logic config_strap_pin,
	input wire logic pulse_mode_sync_pin,
	input wire logic enable_pin,
	input wire logic pwm_demand,
	input wire logic high_gate_below_2v,
	input wire logic low_gate_below_2v,
	input wire logic zero_cross,
	input wire logic over_temp,
	input wire logic temp_recovered,
	input wire logic min_off_reached,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic high_side_gate_out,
	output logic low_side_gate_out,
	output logic power_good_sync_o,
	output logic power_good_sync_oe,
	output logic active_emi_filter_en,
	output logic error_amp_en,
	output logic comp_node_oe,
	output logic internal_comp_allow,
	output logic spread_en,
	output logic bias_reg_en,
	output logic sleep_state,
	output logic soft_start_discharge
);
	import bgms_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	localparam int SYNC_LO = PERIOD_CYC * (100 - `BGMS_SYNC_TOL_PCT) / 100;
	localparam int SYNC_HI = PERIOD_CYC * (100 + `BGMS_SYNC_TOL_PCT) / 100;
	localparam int DEAD_CYC = `BGMS_DEAD_CYC;

	// synchronised copies of every pin-level input
	bgms_async_t async_bus;
	bgms_async_t sync_bus;
	logic uvlo_s, strap_s, pms_s, en_s, dem_s, hol_s, lol_s;
	logic zc_s, ot_s, tr_s, mo_s;
	logic [2:0] code_s;

	assign async_bus = {bias_above_uvlo, strap_code, config_strap_pin,
		pulse_mode_sync_pin, enable_pin, pwm_demand, high_gate_below_2v,
		low_gate_below_2v, zero_cross, over_temp, temp_recovered,
		min_off_reached};
	bgms_sync #(.WIDTH(14)) u_sync (
		.clock(clock),
		.reset(reset),
		.async_in(async_bus),
		.sync_out(sync_bus)
	);
	assign {uvlo_s, code_s, strap_s, pms_s, en_s, dem_s, hol_s, lol_s,
		zc_s, ot_s, tr_s, mo_s} = sync_bus;

	// latched configuration
	logic cfg_latched_reg;
	logic [2:0] cfg_reg;
	logic is_secondary, is_dual, is_spread;

	// capture strap once, hold until bias drops
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_latched_reg <= 1'b0;
			cfg_reg <= `BGMS_STRAP_P_SS0_1PH;
		end else if (!uvlo_s) begin
			cfg_latched_reg <= 1'b0;
		end else if (!cfg_latched_reg) begin
			cfg_latched_reg <= 1'b1;
			// out-of-range codes fall back to plain single phase
			cfg_reg <= (code_s > `BGMS_STRAP_SECONDARY) ?
				`BGMS_STRAP_P_SS0_1PH : code_s;
		end
	end

	// decode of the five strap settings
	assign is_secondary = (cfg_reg == `BGMS_STRAP_SECONDARY);
	assign is_dual = is_secondary || (cfg_reg == `BGMS_STRAP_P_SS0_2PH)
		|| (cfg_reg == `BGMS_STRAP_P_SS1_2PH);
	assign is_spread = (cfg_reg == `BGMS_STRAP_P_SS1_1PH)
		|| (cfg_reg == `BGMS_STRAP_P_SS1_2PH);

	// software control register
	logic [31:0] ctrl_reg;
	logic sw_run;
	assign sw_run = ctrl_reg[`BGMS_CTRL_RUN_BIT];

	// external sync detection on the mode pin
	logic pms_d_reg;
	logic pms_rise;
	logic [7:0] per_cnt_reg;
	logic [1:0] lock_cnt_reg;
	logic ext_locked, per_ok, lock_full;
	assign pms_rise = pms_s && !pms_d_reg;
	assign lock_full = (lock_cnt_reg == `BGMS_LOCK_EDGES);
	// a spreading primary neither uses nor reports a lock
	assign ext_locked = lock_full && !is_spread;
	// period inside tolerance and not above the ceiling
	assign per_ok = (per_cnt_reg >= 8'(SYNC_LO))
		&& (per_cnt_reg <= 8'(SYNC_HI))
		&& (per_cnt_reg >= 8'(`BGMS_SYNC_MIN_CYC));

	// lock only after two good edges in a row
	always_ff @(posedge clock) begin
		if (reset) begin
			pms_d_reg <= 1'b0;
			per_cnt_reg <= 8'h00;
			lock_cnt_reg <= 2'h0;
		end else begin
			pms_d_reg <= pms_s;
			if (pms_rise) begin
				per_cnt_reg <= 8'h01;
				if (!per_ok)
					lock_cnt_reg <= 2'h0;
				else if (!lock_full)
					lock_cnt_reg <= lock_cnt_reg + 2'h1;
			end else begin
				if (per_cnt_reg != 8'hFF)
					per_cnt_reg <= per_cnt_reg + 8'h01;
				// a silent pin is a level again, lock lost
				if (per_cnt_reg > 8'(SYNC_HI))
					lock_cnt_reg <= 2'h0;
			end
		end
	end

	// switching cycle timing source
	logic [7:0] osc_cnt_reg;
	logic use_ext, cycle_start, osc_wrap;
	assign osc_wrap = (osc_cnt_reg == 8'(PERIOD_CYC - 1));
	assign use_ext = is_secondary ||
		(ext_locked && !is_spread && !mo_s);
	assign cycle_start = use_ext ? (pms_rise && ext_locked) : osc_wrap;

	// the counter also gives the phase of the sync output
	always_ff @(posedge clock) begin
		if (reset || cycle_start)
			osc_cnt_reg <= 8'h00;
		else if (!osc_wrap)
			osc_cnt_reg <= osc_cnt_reg + 8'h01;
	end

	// soft-start and thermal state
	logic [15:0] ss_cnt_reg;
	logic ss_active, therm_reg, en_d_reg, lat_d_reg, ss_restart;
	assign ss_active = (ss_cnt_reg != 16'h0000);

	// sticky overtemperature, set wins over recovery
	always_ff @(posedge clock) begin
		if (reset)
			therm_reg <= 1'b0;
		else if (ot_s)
			therm_reg <= 1'b1;
		else if (tr_s)
			therm_reg <= 1'b0;
	end

	assign ss_restart = (cfg_latched_reg && !lat_d_reg)
		|| (en_s && !en_d_reg) || therm_reg;
	always_ff @(posedge clock) begin
		if (reset) begin
			en_d_reg <= 1'b0;
			lat_d_reg <= 1'b0;
			ss_cnt_reg <= 16'h0000;
			soft_start_discharge <= 1'b0;
		end else begin
			en_d_reg <= en_s;
			lat_d_reg <= cfg_latched_reg;
			soft_start_discharge <= ss_restart;
			if (ss_restart)
				ss_cnt_reg <= 16'(SS_CYC);
			else if (ss_active)
				ss_cnt_reg <= ss_cnt_reg - 16'h0001;
		end
	end

	// conduction mode
	logic de_sel, de_active, run;
	// pin level selects the mode when not a clock
	assign de_sel = pms_s && !ext_locked && !is_secondary;
	// pre-bias start always emulates the diode
	assign de_active = de_sel || ss_active;
	assign run = cfg_latched_reg && en_s && sw_run && !therm_reg
		&& !sleep_state;

	// missed-cycle count and sleep
	logic [4:0] miss_reg;
	logic pulse_issued;
	assign pulse_issued = cycle_start && dem_s;

	// sleep after sixteen misses, wake on demand
	always_ff @(posedge clock) begin
		if (reset) begin
			miss_reg <= 5'h00;
			sleep_state <= 1'b0;
		end else if (pulse_issued || !de_sel) begin
			miss_reg <= 5'h00;
			sleep_state <= 1'b0;
		end else if (cycle_start) begin
			if (miss_reg != `BGMS_MISS_LIMIT)
				miss_reg <= miss_reg + 5'h01;
			// the sixteenth miss itself enters sleep, not the one after
			if (miss_reg == `BGMS_MISS_LIMIT - 5'h01)
				sleep_state <= 1'b1;
		end
	end

	// gate interlock state machine
	bgms_gate_e st_reg, st_next;
	logic [3:0] dead_reg;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			BGMS_IDLE: begin
				if (run && pulse_issued)
					st_next = BGMS_LO_WAIT;
			end
			BGMS_LO_WAIT: begin
				if (!run)
					st_next = BGMS_IDLE;
				else if (lol_s)
					st_next = BGMS_HS_ON;
			end
			BGMS_HS_ON: begin
				// current comparator or shutdown ends the on time
				if (!run || !dem_s)
					st_next = BGMS_HO_WAIT;
			end
			BGMS_HO_WAIT: begin
				if (hol_s)
					st_next = BGMS_DEAD;
			end
			BGMS_DEAD: begin
				if (dead_reg == 4'h0)
					st_next = run ? BGMS_LS_ON : BGMS_IDLE;
			end
			BGMS_LS_ON: begin
				// reverse current ends the low side
				if (!run || (de_active && zc_s))
					st_next = BGMS_IDLE;
				else if (pulse_issued)
					st_next = BGMS_LO_WAIT;
			end
		endcase
	end

	// gate outputs only from exclusive states
	always_ff @(posedge clock) begin
		if (reset) begin
			st_reg <= BGMS_IDLE;
			dead_reg <= 4'h0;
			high_side_gate_out <= 1'b0;
			low_side_gate_out <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (st_next == BGMS_DEAD && st_reg != BGMS_DEAD)
				dead_reg <= 4'(DEAD_CYC - 1);
			else if (dead_reg != 4'h0)
				dead_reg <= dead_reg - 4'h1;
			high_side_gate_out <= (st_next == BGMS_HS_ON);
			low_side_gate_out <= (st_next == BGMS_LS_ON);
		end
	end

	// configuration-driven outputs and power-good/sync pin
	logic sync_phase;
	assign sync_phase = (osc_cnt_reg >= 8'(PERIOD_CYC / 2));
	always_ff @(posedge clock) begin
		if (reset) begin
			power_good_sync_o <= 1'b0;
			power_good_sync_oe <= 1'b1;
			active_emi_filter_en <= 1'b0;
			error_amp_en <= 1'b0;
			comp_node_oe <= 1'b0;
			internal_comp_allow <= 1'b0;
			spread_en <= 1'b0;
			bias_reg_en <= 1'b0;
		end else begin
			// strap pin becomes the filter enable
			active_emi_filter_en <= cfg_latched_reg && strap_s;
			error_amp_en <= cfg_latched_reg && !is_secondary;
			comp_node_oe <= cfg_latched_reg && !is_secondary;
			// only the shared external node in dual phase
			internal_comp_allow <= cfg_latched_reg && !is_dual;
			spread_en <= cfg_latched_reg && is_spread;
			bias_reg_en <= !therm_reg;
			if (therm_reg || !cfg_latched_reg) begin
				power_good_sync_o <= 1'b0;
				power_good_sync_oe <= 1'b1;
			end else if (is_dual && !is_secondary) begin
				power_good_sync_o <= sync_phase;
				power_good_sync_oe <= !de_active;
			end else begin
				// open drain: release once regulation is reached
				power_good_sync_o <= 1'b0;
				power_good_sync_oe <= ss_active || !en_s;
			end
		end
	end

	// apb slave, one wait state, registered answer
	logic apb_acc, ctrl_hit, stat_hit;
	logic [31:0] stat_word;
	assign apb_acc = psel && penable && !pready;
	assign ctrl_hit = (paddr == `BGMS_CTRL_ADDR);
	assign stat_hit = (paddr == `BGMS_STAT_ADDR);
	assign stat_word = {18'h00000, st_reg, ss_active, therm_reg,
		sleep_state, ext_locked, cfg_latched_reg, cfg_reg};

	always_ff @(posedge clock) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			ctrl_reg <= `BGMS_CTRL_RESET;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc && !ctrl_hit && !stat_hit;
			prdata <= 32'h00000000;
			if (apb_acc && pwrite && ctrl_hit)
				ctrl_reg <= {31'h00000000, pwdata[`BGMS_CTRL_RUN_BIT]};
			if (apb_acc && !pwrite && ctrl_hit)
				prdata <= ctrl_reg;
			if (apb_acc && !pwrite && stat_hit)
				prdata <= stat_word;
		end
	end

	// checks
	// gates exclusive
	chk_gates_exclusive: assert property (
		!(high_side_gate_out && low_side_gate_out))
		else $error("both gate outputs high");

	// low side follows high gate below 2 V
	chk_lo_after_ho: assert property (
		$rose(low_side_gate_out) |-> $past(st_reg) == BGMS_DEAD
		&& !$past(high_side_gate_out, 2))
		else $error("low side rose without dead time");

	// high side follows low gate below 2 V
	chk_ho_after_lo: assert property (
		$rose(high_side_gate_out) |-> $past(lol_s) && !$past(low_side_gate_out))
		else $error("high side rose before low gate fell");

	// latched code holds while bias stays up
	chk_strap_held: assert property (
		cfg_latched_reg && $past(cfg_latched_reg) |-> $stable(cfg_reg))
		else $error("strap setting changed while latched");

	// spread primary never takes external timing
	chk_spread_nosync: assert property (
		is_spread |-> !use_ext)
		else $error("spread primary synchronised externally");

	// filter enable follows strap after latch
	chk_aef_follow: assert property (
		cfg_latched_reg && strap_s |=> active_emi_filter_en)
		else $error("filter enable not following strap");

	chk_secondary_hiz: assert property (
		cfg_latched_reg && is_secondary |=> !comp_node_oe && !error_amp_en)
		else $error("secondary drives compensation node");

	// sleep only in emulation after the limit
	chk_sleep_entry: assert property (
		$rose(sleep_state) |->
		$past(miss_reg) == `BGMS_MISS_LIMIT - 5'h01
		&& $past(de_sel))
		else $error("sleep entered without sixteen misses");

	// zero cross ends low side on the next cycle
	chk_zero_cross: assert property (
		st_reg == BGMS_LS_ON && de_active && zc_s |=> !low_side_gate_out)
		else $error("low side stayed on at zero cross");

	// shutdown forces gates off and bias off
	chk_thermal_off: assert property (
		therm_reg |=> !high_side_gate_out && !low_side_gate_out
		&& !bias_reg_en)
		else $error("outputs active in thermal shutdown");

	cov_pulse: cover property ($rose(high_side_gate_out));
	cov_sleep: cover property ($rose(sleep_state));
	cov_lock: cover property ($rose(ext_locked));
	cov_thermal: cover property ($fell(therm_reg));
endmodule

/* hdl/bgms_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of levels
module bgms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage is read only by the second stage
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* testbench/bgms_power_stage.sv */
`timescale 1ns/1ps
// external switch pair: gate voltage decays some clocks after drive stops
module bgms_power_stage (
	input wire logic clock,
	input wire logic slow,
	input wire logic high_side_gate_out,
	input wire logic low_side_gate_out,
	output logic high_gate_below_2v,
	output logic low_gate_below_2v
);
	int hi_off = 0; // clocks since the high gate was released
	int lo_off = 0; // clocks since the low gate was released
	int lim; // decay time, longer for large or paralleled switches
	assign lim = slow ? 6 : 1;
	// unknown drive counts as on, so the flag never claims a safe gate early
	always @(posedge clock) begin
		hi_off <= (high_side_gate_out !== 1'b0) ? 0 : hi_off + 1;
		lo_off <= (low_side_gate_out !== 1'b0) ? 0 : lo_off + 1;
	end
	assign high_gate_below_2v = hi_off >= lim;
	assign low_gate_below_2v = lo_off >= lim;
endmodule

/* testbench/buck_gate_mode_sequencer_test.sv */
`timescale 1ns/1ps
`include "bgms_map.svh"
module buck_gate_mode_sequencer_test;
	import bgms_pkg::*;
	// one row: strap code, sync period and edges, expected status
	typedef struct {
		logic [2:0] code;
		int per;
		int edges;
		logic [2:0] cfg;
		logic spr;
		logic dual;
		logic lock;
	} bgms_row_s;
	bgms_row_s rows[6] = '{
		'{3'h0, 40, 4, 3'h0, 1'b0, 1'b0, 1'b1},
		'{3'h1, 40, 4, 3'h1, 1'b1, 1'b0, 1'b0},
		'{3'h2, 40, 1, 3'h2, 1'b0, 1'b1, 1'b0},
		'{3'h3, 44, 4, 3'h3, 1'b1, 1'b1, 1'b0},
		'{3'h4, 40, 0, 3'h4, 1'b0, 1'b1, 1'b0},
		'{3'h7, 60, 4, 3'h0, 1'b0, 1'b0, 1'b0}};
	logic clock = 1'b0, reset = 1'b1, bias_above_uvlo = 1'b0;
	logic [2:0] strap_code = 3'h0;
	logic config_strap_pin = 1'b0, pulse_mode_sync_pin = 1'b0;
	logic enable_pin = 1'b0, pwm_demand = 1'b0, zero_cross = 1'b0;
	logic over_temp = 1'b0, temp_recovered = 1'b0, min_off_reached = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, high_gate_below_2v, low_gate_below_2v;
	logic high_side_gate_out, low_side_gate_out, power_good_sync_o;
	logic power_good_sync_oe, active_emi_filter_en, error_amp_en;
	logic comp_node_oe, internal_comp_allow, spread_en, bias_reg_en;
	logic sleep_state, soft_start_discharge, hs_q, ls_q;
	logic slow = 1'b0, demand_on = 1'b0;
	int n_errors = 0, num_checks = 0, n_hs = 0, hg_n = 0, lg_n = 0;
	int dem_cnt = 0, k, hs0;
	// shortened soft-start keeps the run brief
	bgms_sequencer #(.PERIOD_CYC(40), .SS_CYC(20)) u_bgms_sequencer (
		.clock, .reset, .bias_above_uvlo, .strap_code, .config_strap_pin,
		.pulse_mode_sync_pin, .enable_pin, .pwm_demand, .high_gate_below_2v,
		.low_gate_below_2v, .zero_cross, .over_temp, .temp_recovered,
		.min_off_reached, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .high_side_gate_out, .low_side_gate_out,
		.power_good_sync_o, .power_good_sync_oe, .active_emi_filter_en,
		.error_amp_en, .comp_node_oe, .internal_comp_allow, .spread_en,
		.bias_reg_en, .sleep_state, .soft_start_discharge);
	bgms_power_stage u_bgms_power_stage (.clock, .slow, .high_side_gate_out,
		.low_side_gate_out, .high_gate_below_2v, .low_gate_below_2v);
	always #25 clock = ~clock;
	// compare and count, four-state exact
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one apb transfer; waits for pready, no latency assumed
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int w;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge clock);
			w++;
		end while (pready !== 1'b1 && w < 20);
		rd = prdata;
		er = pslverr;
		check(pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never reassigns psel in one step
		@(posedge clock);
	endtask
	// drop the bias rail, set the strap, raise the rail again
	task automatic latch_cfg(input logic [2:0] c);
		bias_above_uvlo <= 1'b0;
		strap_code <= c;
		tick(4);
		bias_above_uvlo <= 1'b1;
		tick(6);
	endtask
	// current comparator model: demand drops after ten clocks of high
	// side, so every switching cycle starts with a pulse wanted
	always @(posedge clock) begin
		dem_cnt <= (high_side_gate_out === 1'b1) ? dem_cnt + 1 : 0;
		pwm_demand <= demand_on && dem_cnt < 10;
	end
	// gate monitor: overlap and adaptive dead time on every edge
	always @(posedge clock) begin
		hs_q <= high_side_gate_out;
		ls_q <= low_side_gate_out;
		hg_n <= high_gate_below_2v ? hg_n + 1 : 0;
		lg_n <= low_gate_below_2v ? lg_n + 1 : 0;
		if (!reset) begin
			check(high_side_gate_out & low_side_gate_out, 1'b0);
			if (high_side_gate_out === 1'b1 && hs_q !== 1'b1) begin
				n_hs <= n_hs + 1;
				check(lg_n >= 2, 1'b1);
			end
			if (low_side_gate_out === 1'b1 && ls_q !== 1'b1)
				check(hg_n >= 2, 1'b1);
		end
	end
	// watchdog sized well above the whole sequence
	initial begin
		tick(60000);
		n_errors++;
		end_of_test;
	end
	initial begin
		tick(10);
		reset <= 1'b0;
		tick(1);
		check({high_side_gate_out, low_side_gate_out}, 2'b00);
		apb(1'b0, `BGMS_CTRL_ADDR, 32'h0);
		check(rd, `BGMS_CTRL_RESET);
		apb(1'b1, `BGMS_CTRL_ADDR, 32'hFFFFFFFF);
		apb(1'b0, `BGMS_CTRL_ADDR, 32'h0);
		check(rd, 32'h00000001);
		// unmapped word answers with an error and no data
		apb(1'b0, 12'h008, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		// system enables the controller at start-up
		enable_pin <= 1'b1;
		foreach (rows[i]) begin
			latch_cfg(rows[i].code);
			repeat (rows[i].edges) begin
				pulse_mode_sync_pin <= 1'b1;
				tick(rows[i].per / 2);
				pulse_mode_sync_pin <= 1'b0;
				tick(rows[i].per / 2);
			end
			apb(1'b0, `BGMS_STAT_ADDR, 32'h0);
			check(rd[3:0], {1'b1, rows[i].cfg});
			check(rd[4], rows[i].lock);
			check(spread_en, rows[i].spr);
			check(internal_comp_allow, !rows[i].dual);
			if (rows[i].code == 3'h4)
				check({error_amp_en, comp_node_oe}, 2'b00);
		end
		// strap moves after latch: setting holds, pin drives the filter
		latch_cfg(3'h1);
		strap_code <= 3'h3;
		config_strap_pin <= 1'b1;
		tick(5);
		apb(1'b0, `BGMS_STAT_ADDR, 32'h0);
		check(rd[2:0], 3'h1);
		check(active_emi_filter_en, 1'b1);
		config_strap_pin <= 1'b0;
		tick(5);
		check(active_emi_filter_en, 1'b0);
		// dual primary in forced pwm, then slow gates
		latch_cfg(3'h2);
		demand_on <= 1'b1;
		tick(300);
		check(n_hs > 4, 1'b1);
		k = 0;
		repeat (80) begin
			tick(1);
			if ((power_good_sync_oe ? power_good_sync_o : 1'b1) === 1'b1)
				k++;
		end
		check(k, 40);
		slow <= 1'b1;
		hs0 = n_hs;
		tick(300);
		check(n_hs > hs0, 1'b1);
		apb(1'b1, `BGMS_CTRL_ADDR, 32'h0);
		tick(5);
		hs0 = n_hs;
		tick(200);
		check(n_hs, hs0);
		apb(1'b1, `BGMS_CTRL_ADDR, 32'h1);
		slow <= 1'b0;
		// emulation: sync output stops, zero cross ends the low side
		pulse_mode_sync_pin <= 1'b1;
		tick(10);
		check(power_good_sync_oe, 1'b0);
		k = 0;
		while (low_side_gate_out !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
		zero_cross <= 1'b1;
		tick(5);
		check(low_side_gate_out, 1'b0);
		zero_cross <= 1'b0;
		demand_on <= 1'b0;
		k = 0;
		while (sleep_state !== 1'b1 && k < 1500) begin
			tick(1);
			k++;
		end
		check({sleep_state, k >= 600, k < 645}, 3'b111);
		demand_on <= 1'b1;
		tick(100);
		check(sleep_state, 1'b0);
		// forced pwm never sleeps
		pulse_mode_sync_pin <= 1'b0;
		demand_on <= 1'b0;
		tick(1000);
		check(sleep_state, 1'b0);
		// re-enable restarts the soft-start from the bottom
		enable_pin <= 1'b0;
		tick(5);
		enable_pin <= 1'b1;
		tick(4);
		check(soft_start_discharge, 1'b1);
		apb(1'b0, `BGMS_STAT_ADDR, 32'h0);
		check(rd[7], 1'b1);
		// overtemperature shutdown and restart after cooling
		demand_on <= 1'b1;
		over_temp <= 1'b1;
		tick(6);
		check({high_side_gate_out, low_side_gate_out, power_good_sync_o,
			power_good_sync_oe, bias_reg_en, soft_start_discharge},
			6'b000101);
		over_temp <= 1'b0;
		temp_recovered <= 1'b1;
		hs0 = n_hs;
		tick(300);
		check(n_hs > hs0, 1'b1);
		// secondary switches only on the primary's sync edges
		latch_cfg(3'h4);
		hs0 = n_hs;
		repeat (8) begin
			pulse_mode_sync_pin <= 1'b1;
			tick(20);
			pulse_mode_sync_pin <= 1'b0;
			tick(20);
		end
		check(n_hs >= hs0 + 4, 1'b1);
		hs0 = n_hs;
		tick(200);
		check(n_hs, hs0);
		end_of_test;
	end
endmodule
